//--- logic/fsc_top.sv
// status, flag status and configuration register logic of a serial flash
// assumes the memory engine runs on i_clk and the host owns the link clock
//
// Contract
// - status write keeps latch and progress bits
// - protected sectors refuse program and erase
// - timed cycle starts when select returns high
// - cycle ends well under eight milliseconds
// - progress bit reads 1 during cycle
// - flag bit 7 is inverse of progress
// - flag bit 6 shows erase suspension
// - flag bit 5 shows erase failure
// - flag bit 4 shows program failure
// - flag bit 2 shows program suspension
// - flag bit 1 shows protected target attempt
// - flag bit 0 shows address width
// - flag read anytime, byte repeats continuously
// - config top nibble sets dummy count
// - default dummy count ten quad, else eight
// - config bit 0 picks power-up width
// - command on line 0, answer line 1
// - config read gives zeros after 16 bits
// - status byte repeats until select high
`timescale 1ns/100ps
`include "fsc_regs.svh"
module fsc_top #(
	parameter int WS_CYCLES   = `FSC_WS_CYCLES,
	parameter int SECTOR_BITS = 10
) (
	input  wire logic                   i_clk,               // core clock
	input  wire logic                   i_rst,               // async reset
	input  wire logic                   i_link_clk,          // serial clock
	input  wire logic                   i_chip_select_low,   // select, low
	input  wire logic                   i_serial_line_0,     // data in
	output logic                        o_serial_line_1,     // data out
	output logic                        o_serial_line_1_oe,  // out enable
	input  wire fsc_pkg::fsc_read_mode_t i_read_mode,        // fast read kind
	input  wire logic                   i_op_busy,           // program/erase
	input  wire logic                   i_op_start,          // op request
	input  wire logic                   i_op_erase,          // op is erase
	input  wire logic [SECTOR_BITS-1:0] i_op_sector,         // op target
	input  wire logic                   i_op_fail,           // op failed
	input  wire logic                   i_erase_suspend,     // erase held
	input  wire logic                   i_write_suspend,     // program held
	output logic                        o_op_allow,          // target open
	output logic [7:0]                  o_status,            // status reg
	output logic [7:0]                  o_flag_status,       // flag reg
	output logic [15:0]                 o_config,            // config reg
	output logic [3:0]                  o_dummy_cycles,      // dummy count
	output logic                        o_addr_4byte         // 4-byte mode
);
	import fsc_pkg::*;

	// ******************************
	// helpers
	// ******************************
	function automatic logic is_prot(
		input logic [SECTOR_BITS-1:0] sec,
		input logic [3:0]             bp,
		input logic                   tb
	);
		logic [SECTOR_BITS:0] size;
		logic [SECTOR_BITS:0] top;
		logic                 res;
		size = '0;
		top  = '0;
		res  = 1'b0;
		if (bp == 4'h0) begin
			res = 1'b0;
		end else if (32'(bp) > SECTOR_BITS) begin
			res = 1'b1;
		end else begin
			size = (SECTOR_BITS+1)'(1) << (bp - 4'h1);
			top  = (SECTOR_BITS+1)'(1) << SECTOR_BITS;
			if (tb) begin
				res = {1'b0, sec} < size;
			end else begin
				res = {1'b0, sec} >= (top - size);
			end
		end
		return res;
	endfunction

	function automatic logic read_bit(
		input logic [7:0]  cmd,
		input logic [4:0]  idx,
		input logic [31:0] src
	);
		logic res;
		res = 1'b0;
		if (cmd == `FSC_CMD_READ_STATUS) begin
			res = src[31 - 32'(idx[2:0])];
		end else if (cmd == `FSC_CMD_READ_FLAG) begin
			res = src[23 - 32'(idx[2:0])];
		end else if (idx < `FSC_CFG_BITS) begin
			res = src[15 - 32'(idx[3:0])];
		end
		return res;
	endfunction

	// ******************************
	// link side, serial clock
	// ******************************
	fsc_link_t   l_reg;
	fsc_link_t   l_next;
	fsc_core_t   c_reg;
	fsc_core_t   c_next;
	logic        link_rst;
	logic [31:0] snap;
	logic [7:0]  cmd_w;
	logic [1:0]  core_in;

	// select high clears the frame at once, so no edge is needed after it
	assign link_rst = i_rst | i_chip_select_low;

	fsc_sync #(
		.W      (32),
		.FILTER (1'b1)
	) u_snap (
		.i_clk (i_link_clk),
		.i_rst (i_rst),
		.i_d   ({c_reg.status, c_reg.flag, c_reg.cfg}),
		.o_q   (snap)
	);

	assign cmd_w = {l_reg.cmd[6:0], i_serial_line_0};

	always_comb begin
		l_next = l_reg;
		case (l_reg.st)
			FSC_LK_CMD: begin
				l_next.cmd = cmd_w;
				l_next.cnt = l_reg.cnt + 5'h1;
				if (l_reg.cnt == 5'h7) begin
					l_next.cnt = 5'h0;
					l_next.st  = FSC_LK_HOLD;
					if (cmd_w == `FSC_CMD_READ_STATUS || cmd_w == `FSC_CMD_READ_FLAG ||
						cmd_w == `FSC_CMD_READ_CFG) begin
						l_next.st   = FSC_LK_READ;
						l_next.oe   = 1'b1;
						l_next.dout = read_bit(cmd_w, 5'h0, snap);
						l_next.cnt  = 5'h1;
					end else if (cmd_w == `FSC_CMD_WRITE_STATUS ||
						cmd_w == `FSC_CMD_WRITE_CFG) begin
						l_next.st = FSC_LK_DATA;
					end else if (cmd_w == `FSC_CMD_WR_ENABLE ||
						cmd_w == `FSC_CMD_WR_DISABLE) begin
						l_next.done = 1'b1;
					end
				end
			end
			FSC_LK_DATA: begin
				l_next.din = {l_reg.din[14:0], i_serial_line_0};
				l_next.cnt = l_reg.cnt + 5'h1;
				if ((l_reg.cmd == `FSC_CMD_WRITE_STATUS && l_reg.cnt == 5'h7) ||
					l_reg.cnt == 5'hF) begin
					l_next.done = 1'b1;
					l_next.st   = FSC_LK_HOLD;
				end
			end
			FSC_LK_READ: begin
				l_next.dout = read_bit(l_reg.cmd, l_reg.cnt, snap);
				if (l_reg.cmd != `FSC_CMD_READ_CFG) begin
					l_next.cnt = {2'h0, l_reg.cnt[2:0] + 3'h1};
				end else if (l_reg.cnt != `FSC_CFG_BITS) begin
					l_next.cnt = l_reg.cnt + 5'h1;
				end
			end
			default: begin
				// extra clocks after a complete frame change nothing
				l_next = l_reg;
			end
		endcase
	end

	always_ff @(posedge i_link_clk or posedge link_rst) begin
		if (link_rst) begin
			l_reg <= '{st: FSC_LK_CMD, default: '0};
		end else begin
			l_reg <= l_next;
		end
	end

	assign o_serial_line_1    = l_reg.dout;
	assign o_serial_line_1_oe = l_reg.oe;

	// ******************************
	// core side, i_clk
	// ******************************
	// done is the handshake: cmd and din stand still while it is high
	fsc_sync #(
		.W      (2),
		.FILTER (1'b1)
	) u_pins (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   ({l_reg.done, ~i_chip_select_low}),
		.o_q   (core_in)
	);

	logic prot_now;

	assign prot_now = is_prot(i_op_sector,
		{c_reg.status[`FSC_ST_BP3], c_reg.status[`FSC_ST_BP_HI:`FSC_ST_BP_LO]},
		c_reg.status[`FSC_ST_TB]);

	always_comb begin
		c_next           = c_reg;
		c_next.cs_prev   = core_in[0];
		c_next.done_prev = core_in[1];
		if (core_in[1] && !c_reg.done_prev) begin
			c_next.cmd  = l_reg.cmd;
			c_next.din  = l_reg.din;
			c_next.pend = 1'b1;
		end
		if (c_reg.run) begin
			if (c_reg.timer == 18'h0) begin
				c_next.run                  = 1'b0;
				c_next.status[`FSC_ST_WEL]  = 1'b0;
			end else begin
				c_next.timer = c_reg.timer - 18'h1;
			end
		end
		if (!core_in[0] && c_reg.cs_prev && c_reg.pend) begin     // select back high
			c_next.pend = 1'b0;
			if (c_reg.cmd == `FSC_CMD_WR_ENABLE) begin
				c_next.status[`FSC_ST_WEL] = 1'b1;
			end else if (c_reg.cmd == `FSC_CMD_WR_DISABLE) begin
				c_next.status[`FSC_ST_WEL] = 1'b0;
			end else if (c_reg.status[`FSC_ST_WEL] && !c_reg.run) begin
				if (c_reg.cmd == `FSC_CMD_WRITE_STATUS) begin
					c_next.status = (c_reg.status & ~`FSC_ST_WR_MASK) |
						(c_reg.din[7:0] & `FSC_ST_WR_MASK);
				end else begin
					c_next.cfg = c_reg.din | `FSC_CFG_FORCE;
				end
				c_next.run   = 1'b1;
				c_next.timer = 18'(WS_CYCLES - 1);
			end
		end
		c_next.status[`FSC_ST_WIP] = c_next.run | i_op_busy;
		if (i_op_start) begin
			c_next.e_err = 1'b0;
			c_next.w_err = 1'b0;
			c_next.p_err = 1'b0;
		end
		// sets follow clears so an event is never lost to a clear
		if (i_op_start && prot_now) begin
			c_next.p_err = 1'b1;
			c_next.e_err = c_next.e_err | i_op_erase;
			c_next.w_err = c_next.w_err | ~i_op_erase;
		end
		if (i_op_fail) begin
			c_next.e_err = c_next.e_err | i_op_erase;
			c_next.w_err = c_next.w_err | ~i_op_erase;
		end
		c_next.flag[`FSC_FL_READY] = ~c_next.status[`FSC_ST_WIP];
		c_next.flag[`FSC_FL_ESUSP] = i_erase_suspend;
		c_next.flag[`FSC_FL_EERR]  = c_next.e_err;
		c_next.flag[`FSC_FL_WERR]  = c_next.w_err;
		c_next.flag[`FSC_FL_RSVD]  = 1'b0;
		c_next.flag[`FSC_FL_WSUSP] = i_write_suspend;
		c_next.flag[`FSC_FL_PROT]  = c_next.p_err;
		c_next.flag[`FSC_FL_ADDR4] = c_reg.addr4;
		c_next.dummy = c_next.cfg[`FSC_CFG_DUMMY_HI:`FSC_CFG_DUMMY_LO];
		if (c_next.dummy == 4'h0 || c_next.dummy == 4'hF) begin
			c_next.dummy = (i_read_mode == FSC_RD_QUAD) ?
				`FSC_DUMMY_QUAD : `FSC_DUMMY_OTHER;
		end
	end

	// width mode is taken from the stored config only at reset
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			c_reg        <= '0;
			c_reg.status <= `FSC_ST_RESET;
			c_reg.cfg    <= `FSC_CFG_RESET;
			c_reg.addr4  <= ~1'(`FSC_CFG_RESET >> `FSC_CFG_ADDR);
			c_reg.flag   <= 8'h80 | {7'h0, ~1'(`FSC_CFG_RESET >> `FSC_CFG_ADDR)};
			c_reg.dummy  <= `FSC_DUMMY_OTHER;
		end else begin
			c_reg <= c_next;
		end
	end

	assign o_op_allow     = ~prot_now;
	assign o_status       = c_reg.status;
	assign o_flag_status  = c_reg.flag;
	assign o_config       = c_reg.cfg;
	assign o_dummy_cycles = c_reg.dummy;
	assign o_addr_4byte   = c_reg.addr4;

	// ******************************
	// checks
	// ******************************
	localparam int WS_MAX = `FSC_WS_MAX_CYC;

	a_cycle_bound: assert property (@(posedge i_clk) disable iff (i_rst)
		c_reg.run |-> 32'(c_reg.timer) < WS_MAX - 1)
		else $error("write cycle longer than allowed");
	a_cycle_end: assert property (@(posedge i_clk) disable iff (i_rst)
		c_reg.run && c_reg.timer == 18'h0 && !c_reg.pend |=>
		!c_reg.run && !c_reg.status[`FSC_ST_WEL])
		else $error("write cycle did not end cleanly");
	a_start_cause: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(c_reg.run) |-> $past(c_reg.pend) && $past(c_reg.status[`FSC_ST_WEL]) &&
		$past(c_reg.cs_prev) && !$past(core_in[0]))
		else $error("write cycle without enable or before release");
	a_bits_kept: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(c_reg.run) |-> c_reg.status[`FSC_ST_WEL] && c_reg.status[`FSC_ST_WIP])
		else $error("latch or progress bit lost");
	a_ready_inverse: assert property (@(posedge i_clk) disable iff (i_rst)
		c_reg.flag[`FSC_FL_READY] == !c_reg.status[`FSC_ST_WIP])
		else $error("ready flag not inverse of progress");
	a_suspend_flags: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 c_reg.flag[`FSC_FL_ESUSP] == $past(i_erase_suspend) &&
		c_reg.flag[`FSC_FL_WSUSP] == $past(i_write_suspend))
		else $error("suspend flags wrong");
	a_prot_refuse: assert property (@(posedge i_clk) disable iff (i_rst)
		i_op_start && prot_now |-> !o_op_allow ##1 c_reg.flag[`FSC_FL_PROT])
		else $error("protected target not refused");
	a_erase_err: assert property (@(posedge i_clk) disable iff (i_rst)
		i_op_fail && i_op_erase |=> c_reg.flag[`FSC_FL_EERR])
		else $error("erase failure not flagged");
	a_write_err: assert property (@(posedge i_clk) disable iff (i_rst)
		i_op_fail && !i_op_erase |=> c_reg.flag[`FSC_FL_WERR])
		else $error("program failure not flagged");
	a_addr_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		c_reg.flag[`FSC_FL_ADDR4] == c_reg.addr4 && !c_reg.flag[`FSC_FL_RSVD])
		else $error("address flag wrong");
	a_dummy_default: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 (c_reg.cfg[15:12] == 4'h0 || c_reg.cfg[15:12] == 4'hF) &&
		$past(i_read_mode) == FSC_RD_QUAD |-> c_reg.dummy == `FSC_DUMMY_QUAD)
		else $error("quad default dummy wrong");
	a_cfg_busy: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(c_reg.run) && c_reg.cmd == `FSC_CMD_WRITE_CFG |-> !c_reg.flag[`FSC_FL_READY])
		else $error("config write not busy");
	a_cfg_zeros: assert property (@(posedge i_link_clk) disable iff (link_rst)
		l_reg.st == FSC_LK_READ && l_reg.cmd == `FSC_CMD_READ_CFG &&
		l_reg.cnt == `FSC_CFG_BITS |=> !l_reg.dout)
		else $error("config read not zero after 16 bits");
	a_byte_repeat: assert property (@(posedge i_link_clk) disable iff (link_rst)
		l_reg.st == FSC_LK_READ && l_reg.cmd != `FSC_CMD_READ_CFG |-> l_reg.cnt < 5'h8)
		else $error("status byte index out of range");
	a_drive_read: assert property (@(posedge i_link_clk) disable iff (link_rst)
		l_reg.oe |-> l_reg.st == FSC_LK_READ)
		else $error("line driven outside a read");

	c_cycle_done: cover property (@(posedge i_clk) disable iff (i_rst) $fell(c_reg.run));
	c_refused: cover property (@(posedge i_clk) disable iff (i_rst) i_op_start && !o_op_allow);
	c_cfg_tail: cover property (@(posedge i_link_clk) disable iff (link_rst)
		l_reg.cmd == `FSC_CMD_READ_CFG && l_reg.cnt == `FSC_CFG_BITS);
endmodule

//--- logic/fsc_regs.svh
// command codes, register fields, reset values and timing counts
// assumes a 20 MHz core clock; included by the top only
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

// ******************************
// command codes
// ******************************
`define FSC_CMD_WRITE_STATUS 8'h01
`define FSC_CMD_READ_STATUS  8'h05
`define FSC_CMD_READ_FLAG    8'h70
`define FSC_CMD_READ_CFG     8'hB5
`define FSC_CMD_WRITE_CFG    8'hB1
`define FSC_CMD_WR_ENABLE    8'h06
`define FSC_CMD_WR_DISABLE   8'h04

// ******************************
// status register fields
// ******************************
`define FSC_ST_WIP       0
`define FSC_ST_WEL       1
`define FSC_ST_BP_LO     2
`define FSC_ST_BP_HI     4
`define FSC_ST_TB        5
`define FSC_ST_BP3       6
`define FSC_ST_WR_MASK   8'hFC
`define FSC_ST_RESET     8'h00

// ******************************
// flag status fields
// ******************************
`define FSC_FL_READY     7
`define FSC_FL_ESUSP     6
`define FSC_FL_EERR      5
`define FSC_FL_WERR      4
`define FSC_FL_RSVD      3
`define FSC_FL_WSUSP     2
`define FSC_FL_PROT      1
`define FSC_FL_ADDR4     0

// ******************************
// configuration fields
// ******************************
`define FSC_CFG_DUMMY_HI 15
`define FSC_CFG_DUMMY_LO 12
`define FSC_CFG_ADDR     0
`define FSC_CFG_FORCE    16'h0010
`define FSC_CFG_RESET    16'hFFFF
`define FSC_CFG_BITS     5'h10
`define FSC_DUMMY_QUAD   4'hA
`define FSC_DUMMY_OTHER  4'h8

// ******************************
// timing
// ******************************
`define FSC_CLK_HZ       20000000
`define FSC_WS_TIME_MS   5
`define FSC_WS_MAX_MS    8
`define FSC_WS_CYCLES    ((`FSC_WS_TIME_MS * `FSC_CLK_HZ) / 1000)
`define FSC_WS_MAX_CYC   ((`FSC_WS_MAX_MS * `FSC_CLK_HZ) / 1000)

`endif

//--- logic/fsc_pkg.sv
// types shared by the status and configuration register block
// assumes fsc_regs.svh is on the include path
package fsc_pkg;

	typedef enum logic [3:0] {
		FSC_LK_CMD  = 4'b0001,
		FSC_LK_DATA = 4'b0010,
		FSC_LK_READ = 4'b0100,
		FSC_LK_HOLD = 4'b1000
	} fsc_link_state_t;

	typedef enum logic [1:0] {
		FSC_RD_STD  = 2'h0,
		FSC_RD_DUAL = 2'h1,
		FSC_RD_QUAD = 2'h2
	} fsc_read_mode_t;

	typedef struct packed {
		fsc_link_state_t st;
		logic [4:0]      cnt;
		logic [7:0]      cmd;
		logic [15:0]     din;
		logic            done;
		logic            dout;
		logic            oe;
	} fsc_link_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [15:0] cfg;
		logic        addr4;
		logic        run;
		logic [17:0] timer;
		logic [7:0]  cmd;
		logic [15:0] din;
		logic        pend;
		logic        cs_prev;
		logic        done_prev;
		logic        e_err;
		logic        w_err;
		logic        p_err;
		logic [7:0]  flag;
		logic [3:0]  dummy;
	} fsc_core_t;

endpackage

//--- logic/fsc_sync.sv
// multi-bit level synchroniser, two stages or three with agreement
// assumes each bit is an independent, slowly changing level
`timescale 1ns/100ps
module fsc_sync #(
	parameter int W      = 1,
	parameter bit FILTER = 1'b0
) (
	input  wire logic         i_clk,   // destination clock
	input  wire logic         i_rst,   // async reset, high
	input  wire logic [W-1:0] i_d,     // level from other domain
	output logic      [W-1:0] o_q      // synchronised level
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} fsc_sync_t;

	fsc_sync_t r_reg;
	fsc_sync_t r_next;

	always_comb begin
		r_next    = r_reg;
		r_next.s1 = i_d;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		if (!FILTER) begin
			r_next.q = r_reg.s2;
		end else begin
			// a bit moves only once stages two and three agree
			r_next.q = (r_reg.s2 & r_reg.s3) | (r_reg.q & (r_reg.s2 | r_reg.s3));
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_q = r_reg.q;
endmodule

//--- test/fsc_host_model.sv
// host side of the serial link: select, link clock and line 0
// assumes the device answers on line 1 after the eighth rising edge
`timescale 1ns/100ps
module fsc_host_model (
	output logic      o_link_clk,         // serial clock, still between frames
	output logic      o_chip_select_low,  // frame select, low
	output logic      o_serial_line_0,    // command and data to device
	input  wire logic i_serial_line_1,    // device answer
	input  wire logic i_serial_line_1_oe  // device drives answer
);
	initial begin
		o_link_clk = 1'b0;
		o_chip_select_low = 1'b1;
		o_serial_line_0 = 1'b0;
	end

	// ****
	// one frame: command, ndata bits msb first, nread answer bits
	// ****
	task automatic frame(input logic [7:0] cmd, input logic [15:0] data,
		input int ndata, input int nread, output logic [31:0] rd);
		int nb;
		logic [23:0] sh;
		nb = (nread > 0) ? 7 + nread : 8 + ndata;
		sh = {cmd, 16'(data << (16 - ndata))};
		rd = '0;
		o_chip_select_low = 1'b0;
		#100;
		for (int i = 0; i < nb; i++) begin
			o_serial_line_0 = sh[23];
			sh = sh << 1;
			#15 o_link_clk = 1'b1;
			#15 o_link_clk = 1'b0;
			// answer settles after the rising edge, so falling is safe
			// a released line reads as the inverse, so a late drive shows up
			if (i >= 7)
				rd = {rd[30:0], i_serial_line_1_oe ? i_serial_line_1 : ~i_serial_line_1};
		end
		// line no longer valid: show the inverse, not a stale bit
		o_serial_line_0 = ~o_serial_line_0;
		#250 o_chip_select_low = 1'b1;
		#250;
	endtask
endmodule

//--- test/tb_flash_status_config_regs.sv
// self-checking bench for the status, flag and configuration registers
// assumes fsc_host_model stands in for the serial host
`timescale 1ns/100ps
module tb_flash_status_config_regs;
	import fsc_pkg::*;
	localparam int WS = 40;
	logic           clk, rst, lclk, csn, sdi, sdo, sdo_oe;
	fsc_read_mode_t mode;
	logic           busy, start, erase, fail, esus, wsus, allow, addr4;
	logic [9:0]     sector;
	logic [7:0]     status, flag;
	logic [15:0]    cfg;
	logic [3:0]     dummy;
	logic [31:0]    rd;
	int             n_fail, tests_run;

	fsc_top #(.WS_CYCLES(WS), .SECTOR_BITS(10)) u_dut (
		.i_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_chip_select_low(csn),
		.i_serial_line_0(sdi), .o_serial_line_1(sdo), .o_serial_line_1_oe(sdo_oe),
		.i_read_mode(mode), .i_op_busy(busy), .i_op_start(start), .i_op_erase(erase),
		.i_op_sector(sector), .i_op_fail(fail), .i_erase_suspend(esus),
		.i_write_suspend(wsus), .o_op_allow(allow), .o_status(status),
		.o_flag_status(flag), .o_config(cfg), .o_dummy_cycles(dummy),
		.o_addr_4byte(addr4));

	fsc_host_model u_host (
		.o_link_clk(lclk), .o_chip_select_low(csn), .o_serial_line_0(sdi),
		.i_serial_line_1(sdo), .i_serial_line_1_oe(sdo_oe));

	always #25 clk = ~clk;

	// ****
	// shared tasks
	// ****
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// write latch first, or the write is refused
	task automatic wr(input logic [7:0] cmd, input logic [15:0] data, input int n);
		u_host.frame(8'h06, 16'h0000, 0, 0, rd);
		u_host.frame(cmd, data, n, 0, rd);
	endtask

	// polls the ready flag; n counts the busy cycles seen
	task automatic wait_ready(output int n);
		int k;
		n = 0;
		for (k = 0; k < 20 && flag[7] !== 1'b0; k++) begin
			@(posedge clk);
			#1;
		end
		for (k = 0; k < 200 && flag[7] !== 1'b1; k++) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (k == 200) begin
			n_fail++;
			$display("BAD %0t wait for ready ran out", $time);
			complete_run();
		end
	endtask

	task automatic op(input logic er, input logic [9:0] sec, input logic f);
		@(posedge clk);
		start <= 1'b1;
		erase <= er;
		sector <= sec;
		@(posedge clk);
		start <= 1'b0;
		fail <= f;
		@(posedge clk);
		fail <= 1'b0;
		#1;
	endtask

	// ****
	// scenarios
	// ****
	task automatic t_reset();
		check(status, 8'h00, "status at reset");
		check(flag, 8'h80, "flags at reset");
		check(cfg, 16'hFFFF, "config at reset");
		check(addr4, 1'b0, "address width at reset");
		check(dummy, 4'h8, "default dummy standard");
		check(sdo_oe, 1'b0, "line 1 idle");
	endtask

	task automatic t_reads();
		u_host.frame(8'h70, 16'h0000, 0, 16, rd);
		check(rd[15:0], 16'h8080, "flag byte repeats");
		check(sdo_oe, 1'b0, "line 1 released");
		u_host.frame(8'h05, 16'h0000, 0, 16, rd);
		check(rd[15:0], 16'h0000, "status byte repeats");
	endtask

	task automatic t_status();
		int n;
		u_host.frame(8'h01, 16'h001B, 8, 0, rd);
		repeat (8) @(posedge clk);
		#1;
		check(status, 8'h00, "status write without latch");
		u_host.frame(8'h06, 16'h0000, 0, 0, rd);
		u_host.frame(8'h04, 16'h0000, 0, 0, rd);
		u_host.frame(8'h01, 16'h001B, 8, 0, rd);
		repeat (8) @(posedge clk);
		#1;
		check(status, 8'h00, "status write after disable");
		wr(8'h01, 16'h001B, 8);
		u_host.frame(8'h05, 16'h0000, 0, 8, rd);
		check(rd[1:0], 2'b11, "progress and latch during cycle");
		check(flag[7], 1'b0, "busy during status cycle");
		wait_ready(n);
		check(n > 0 && n < WS, 1'b1, "status cycle length");
		check(status, 8'h18, "status after cycle");
	endtask

	task automatic t_ops();
		op(1'b0, 10'd992, 1'b0);
		check(allow, 1'b0, "top sectors locked");
		check(flag[4:0], 5'h12, "program on locked sector");
		op(1'b1, 10'd991, 1'b1);
		check(allow, 1'b1, "sector below lock open");
		check(flag[5:0], 6'h20, "erase failure");
		op(1'b1, 10'd1023, 1'b0);
		check(flag[5:0], 6'h22, "erase on locked sector");
		op(1'b0, 10'd0, 1'b1);
		check(flag[5:0], 6'h10, "program failure");
		u_host.frame(8'h70, 16'h0000, 0, 8, rd);
		check(rd[7:0], 8'h90, "flag read after program");
		@(posedge clk);
		busy <= 1'b1;
		esus <= 1'b1;
		wsus <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		check(flag & 8'hCC, 8'h44, "busy and suspensions");
		busy <= 1'b0;
		esus <= 1'b0;
		wsus <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check(flag & 8'hCC, 8'h80, "ready, none suspended");
	endtask

	task automatic t_config();
		logic [15:0] codes [4] = '{16'h1FFF, 16'hEFFF, 16'h0FFF, 16'hFFFF};
		logic [3:0] exp;
		int n;
		wr(8'hB1, 16'h5FEF, 16);
		wait_ready(n);
		check(n >= WS - 8 && n <= WS * 8 / 5, 1'b1, "config cycle length");
		check(cfg, 16'h5FFF, "config with bit 4 forced");
		check(dummy, 4'h5, "coded dummy count");
		u_host.frame(8'hB5, 16'h0000, 0, 24, rd);
		check(rd[23:0], 24'h5FFF00, "config then zeros");
		for (int c = 0; c < 4; c++) begin
			wr(8'hB1, codes[c], 16);
			wait_ready(n);
			for (int m = 0; m < 3; m++) begin
				@(posedge clk);
				mode <= fsc_read_mode_t'(m[1:0]);
				repeat (3) @(posedge clk);
				#1;
				exp = codes[c][15:12];
				if (exp == 4'h0 || exp == 4'hF)
					exp = (m == 2) ? 4'hA : 4'h8;
				check(dummy, exp, "dummy count");
			end
		end
		check(flag[0], 1'b0, "width flag stays three-byte");
	endtask

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		mode = FSC_RD_STD;
		{busy, start, erase, fail, esus, wsus} = 6'h00;
		sector = 10'h000;
		n_fail = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		t_reset();
		t_reads();
		t_status();
		t_ops();
		t_config();
		complete_run();
	end
endmodule
